// File: src/logic_cell_pkg.sv
/*
  Shared constants for the logic cell cluster: register map, field
  positions, reset values and the bus answer state.
  Assumes a 32-bit classic Wishbone slave decoding byte addresses.
*/
package logic_cell_pkg;

  localparam int CELLS   = 10;
  localparam int SEG_LEN = 5;

  localparam logic [7:0] MODE_OFS   = 8'h00;
  localparam logic [7:0] LUT_OFS    = 8'h04;
  localparam logic [7:0] CTRL_OFS   = 8'h08;
  localparam logic [7:0] RESULT_OFS = 8'h0c;

  localparam int MODE_ARITH_BIT    = 0;
  localparam int MODE_CARRY_LUT    = 1;
  localparam int MODE_PACK_BIT     = 2;
  localparam int MODE_PRESET_BIT   = 3;
  localparam int MODE_CHIPRST_BIT  = 4;
  localparam int MODE_LUTCHAIN_BIT = 5;
  localparam int MODE_START_LSB    = 8;
  localparam int MODE_START_W      = 4;

  localparam int CTRL_ADDNSUB_BIT = 0;
  localparam int CTRL_SCLR_BIT    = 1;
  localparam int CTRL_SLOAD_BIT   = 2;
  localparam int CTRL_ENA_BIT     = 3;
  localparam int CTRL_ACLR0_BIT   = 4;
  localparam int CTRL_ACLR1_BIT   = 5;
  localparam int CTRL_ALD_BIT     = 6;

  localparam int RES_COMB_LSB  = 10;
  localparam int RES_CARRY_BIT = 20;

  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] LUT_RST  = 16'h0000;
  localparam logic [7:0]  CTRL_RST = 8'h08;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

endpackage

// File: src/logic_cell.sv
/*
  One logic cell: four-input look-up function for normal mode and the
  carry-select sum and carry pair for dynamic arithmetic mode.
  Purely combinational; the owning cluster holds the cell register.
*/
module logic_cell (
  input  wire logic        operand_a_in,
  input  wire logic        operand_b_in,
  input  wire logic        third_data_in,
  input  wire logic        fourth_data_in,
  input  wire logic        carry_low_chain_in,
  input  wire logic        carry_high_chain_in,
  input  wire logic        chain_select,
  input  wire logic        lut_chain_in,
  input  wire logic [15:0] lut_mask,
  input  wire logic        arith_mode,
  input  wire logic        carry_as_lut,
  input  wire logic        lut_chain_en,
  input  wire logic        subtract,
  output logic             result,
  output logic             carry_low_chain_out,
  output logic             carry_high_chain_out
);

  logic       b_eff;
  logic       a_eff;
  logic       sel_level;
  logic [3:0] lut_in;
  logic       sum0;
  logic       sum1;
  logic       cy0;
  logic       cy1;

  always_comb
  begin
    b_eff     = operand_b_in ^ subtract;
    a_eff     = lut_chain_en ? lut_chain_in : operand_a_in;
    sel_level = chain_select ? carry_high_chain_in : carry_low_chain_in;
    lut_in    = {fourth_data_in, carry_as_lut ? sel_level : third_data_in,
                 operand_b_in, a_eff};
    sum0      = operand_a_in ^ b_eff;
    sum1      = ~sum0;
    cy0       = operand_a_in & b_eff;
    cy1       = operand_a_in | b_eff;
    carry_low_chain_out  = carry_low_chain_in ? cy1 : cy0;
    carry_high_chain_out = carry_high_chain_in ? cy1 : cy0;
    result = arith_mode ? (sel_level ? sum1 : sum0) : lut_mask[lut_in];
  end

endmodule // logic_cell

// File: src/cell_cluster.sv
/*
  A cluster of ten logic cells with their registers, the carry-select
  chain, cluster-wide register controls and a classic Wishbone slave.
  Assumes data inputs come from logic on clk; chip_wide_reset_n is a pin.
*/
// The Wishbone slave port and the placing of the registers were decided locally.
module cell_cluster (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [9:0]  operand_a_in,
  input  wire logic [9:0]  operand_b_in,
  input  wire logic [9:0]  third_data_in,
  input  wire logic [9:0]  fourth_data_in,
  input  wire logic        cluster_carry_in,
  input  wire logic        lut_chain_in,
  input  wire logic        reg_chain_in,
  input  wire logic        chip_wide_reset_n,
  output logic      [9:0]  cell_q,
  output logic             cluster_carry_out,
  output logic             lut_chain_out
);

  localparam int N = logic_cell_pkg::CELLS;
  localparam int S = logic_cell_pkg::SEG_LEN;

  // ------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------
  function automatic logic [31:0] merge_sel(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  sel);
    logic [31:0] w;
    w = old_w;
    for (int k = 0; k < 4; k++)
    begin
      if (sel[k])
      begin
        w[k*8 +: 8] = new_w[k*8 +: 8];
      end
    end
    return w;
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  logic                      [15:0] mode_reg;
  logic                      [15:0] mode_next;
  logic                      [15:0] lut_reg;
  logic                      [15:0] lut_next;
  logic                      [7:0]  ctrl_reg;
  logic                      [7:0]  ctrl_next;
  logic                      [31:0] dat_next;
  logic                      [31:0] merged;
  logic                             ack_next;
  logic                             wr_en;
  logic [9:0]                       comb_vec;
  logic                             carry10;
  logic                             arith;
  logic [3:0]                       start;
  logic_cell_pkg::bus_state_t       bus_state_reg;
  logic_cell_pkg::bus_state_t       bus_state_next;

  always_comb
  begin
    mode_next      = mode_reg;
    lut_next       = lut_reg;
    ctrl_next      = ctrl_reg;
    dat_next       = 32'h0000_0000;
    merged         = 32'h0000_0000;
    ack_next       = 1'b0;
    bus_state_next = logic_cell_pkg::BUS_IDLE;
    wr_en          = 1'b0;
    unique case (bus_state_reg)
      logic_cell_pkg::BUS_IDLE:
      begin
        if (wb_cyc_i && wb_stb_i)
        begin
          ack_next       = 1'b1;
          bus_state_next = logic_cell_pkg::BUS_ACK;
          wr_en          = wb_we_i;
        end
      end
      logic_cell_pkg::BUS_ACK:
      begin
        bus_state_next = logic_cell_pkg::BUS_IDLE;
      end
    endcase
    if (hit(wb_adr_i, logic_cell_pkg::MODE_OFS))
    begin
      merged   = merge_sel({16'h0000, mode_reg}, wb_dat_i, wb_sel_i);
      dat_next = {16'h0000, mode_reg};
      if (wr_en)
      begin
        mode_next = merged[15:0];
      end
    end
    else if (hit(wb_adr_i, logic_cell_pkg::LUT_OFS))
    begin
      merged   = merge_sel({16'h0000, lut_reg}, wb_dat_i, wb_sel_i);
      dat_next = {16'h0000, lut_reg};
      if (wr_en)
      begin
        lut_next = merged[15:0];
      end
    end
    else if (hit(wb_adr_i, logic_cell_pkg::CTRL_OFS))
    begin
      merged   = merge_sel({24'h00_0000, ctrl_reg}, wb_dat_i, wb_sel_i);
      dat_next = {24'h00_0000, ctrl_reg};
      if (wr_en)
      begin
        ctrl_next = merged[7:0];
      end
    end
    else if (hit(wb_adr_i, logic_cell_pkg::RESULT_OFS))
    begin
      // Both copies of the result are visible here.
      dat_next = {11'h000, carry10, comb_vec, cell_q};
    end
    if (!ack_next)
    begin
      dat_next = wb_dat_o;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_reg      <= logic_cell_pkg::MODE_RST;
      lut_reg       <= logic_cell_pkg::LUT_RST;
      ctrl_reg      <= logic_cell_pkg::CTRL_RST;
      wb_dat_o      <= 32'h0000_0000;
      wb_ack_o      <= 1'b0;
      bus_state_reg <= logic_cell_pkg::BUS_IDLE;
    end
    else
    begin
      mode_reg      <= mode_next;
      lut_reg       <= lut_next;
      ctrl_reg      <= ctrl_next;
      wb_dat_o      <= dat_next;
      wb_ack_o      <= ack_next;
      bus_state_reg <= bus_state_next;
    end
  end

  // ------------------------------------------------------------------
  // Chip-wide reset pin synchroniser
  // ------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= 1'b1;
    end
    else
    begin
      rst_meta_reg <= chip_wide_reset_n;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ------------------------------------------------------------------
  // Carry-select chain and cells
  // ------------------------------------------------------------------
  logic       preset_mode;
  logic       packed_mode;
  logic       chip_rst;
  logic       aclr;
  logic       ald;
  logic       ena;
  logic       sclr;
  logic       sload;
  logic       addnsub;
  logic [9:0] sub_vec;
  logic [9:0] lo_in;
  logic [9:0] hi_in;
  logic [9:0] lo_out;
  logic [9:0] hi_out;
  logic [9:0] sel_vec;
  logic [9:0] lchain;
  logic       regen5;

  always_comb
  begin
    arith       = mode_reg[logic_cell_pkg::MODE_ARITH_BIT];
    packed_mode = mode_reg[logic_cell_pkg::MODE_PACK_BIT];
    preset_mode = mode_reg[logic_cell_pkg::MODE_PRESET_BIT];
    start       = mode_reg[logic_cell_pkg::MODE_START_LSB +: logic_cell_pkg::MODE_START_W];
    chip_rst    = mode_reg[logic_cell_pkg::MODE_CHIPRST_BIT] & ~rst_sync_reg;
    aclr        = ctrl_reg[logic_cell_pkg::CTRL_ACLR0_BIT]
                | ctrl_reg[logic_cell_pkg::CTRL_ACLR1_BIT];
    ald         = ctrl_reg[logic_cell_pkg::CTRL_ALD_BIT];
    ena         = ctrl_reg[logic_cell_pkg::CTRL_ENA_BIT];
    sclr        = ctrl_reg[logic_cell_pkg::CTRL_SCLR_BIT];
    sload       = ctrl_reg[logic_cell_pkg::CTRL_SLOAD_BIT];
    addnsub     = arith & ctrl_reg[logic_cell_pkg::CTRL_ADDNSUB_BIT];
    // A low fourth input reverses the count direction.
    sub_vec     = {N{arith}} & ({N{addnsub}} ^ ~fourth_data_in);
    regen5      = cluster_carry_in ? hi_out[S-1] : lo_out[S-1];
    carry10     = regen5 ? hi_out[N-1] : lo_out[N-1];
  end

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_cell
      always_comb
      begin
        // Chain start forces both chains; at cell 0 without subtract
        // the previous cluster's carry selects, so chains link.
        if (4'(g) == start)
        begin
          lo_in[g] = sub_vec[g];
          hi_in[g] = sub_vec[g] | (start == 4'h0);
        end
        else if (g == S && start < 4'(S))
        begin
          lo_in[g] = 1'b0;
          hi_in[g] = 1'b1;
        end
        else if (4'(g) > start)
        begin
          lo_in[g] = lo_out[(g > 0) ? g - 1 : 0];
          hi_in[g] = hi_out[(g > 0) ? g - 1 : 0];
        end
        else
        begin
          lo_in[g] = 1'b0;
          hi_in[g] = 1'b0;
        end
        sel_vec[g] = (g < S) ? cluster_carry_in : regen5;
        lchain[g]  = (g == 0) ? lut_chain_in : comb_vec[(g > 0) ? g - 1 : 0];
      end

      logic_cell u_cell (
        .operand_a_in         (operand_a_in[g]),
        .operand_b_in         (operand_b_in[g]),
        .third_data_in        (third_data_in[g]),
        .fourth_data_in       (fourth_data_in[g]),
        .carry_low_chain_in   (lo_in[g]),
        .carry_high_chain_in  (hi_in[g]),
        .chain_select         (sel_vec[g]),
        .lut_chain_in         (lchain[g]),
        .lut_mask             (lut_reg),
        .arith_mode           (arith),
        .carry_as_lut         (mode_reg[logic_cell_pkg::MODE_CARRY_LUT]),
        .lut_chain_en         (mode_reg[logic_cell_pkg::MODE_LUTCHAIN_BIT]),
        .subtract             (sub_vec[g]),
        .result               (comb_vec[g]),
        .carry_low_chain_out  (lo_out[g]),
        .carry_high_chain_out (hi_out[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Cell registers
  // ------------------------------------------------------------------
  // The clear and load controls are register-driven, so they act at the
  // next edge rather than truly asynchronously; priority is preserved.
  logic [9:0] q_next;
  logic       carry_next;
  logic       chain_next;

  always_comb
  begin
    q_next     = cell_q;
    carry_next = carry10;
    chain_next = comb_vec[N-1];
    for (int i = 0; i < N; i++)
    begin
      if (chip_rst)
      begin
        q_next[i] = 1'b0;
      end
      else if (aclr)
      begin
        q_next[i] = 1'b0;
      end
      else if (ald)
      begin
        q_next[i] = preset_mode ? 1'b1 : third_data_in[i];
      end
      else if (ena)
      begin
        if (sclr)
        begin
          q_next[i] = 1'b0;
        end
        else if (sload)
        begin
          q_next[i] = third_data_in[i];
        end
        else if (arith)
        begin
          if (third_data_in[i])
          begin
            q_next[i] = comb_vec[i];
          end
        end
        else if (packed_mode)
        begin
          q_next[i] = (i == 0) ? reg_chain_in : cell_q[(i > 0) ? i - 1 : 0];
        end
        else
        begin
          q_next[i] = comb_vec[i];
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cell_q            <= 10'h000;
      cluster_carry_out <= 1'b0;
      lut_chain_out     <= 1'b0;
    end
    else
    begin
      cell_q            <= q_next;
      cluster_carry_out <= carry_next;
      lut_chain_out     <= chain_next;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  logic [10:0] model_sum;
  logic        quiet;

  always_comb
  begin
    model_sum = 11'({1'b0, operand_a_in})
              + 11'({1'b0, operand_b_in ^ {N{addnsub}}})
              + 11'(addnsub | cluster_carry_in);
    quiet     = !chip_rst && !aclr && !ald;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_bus_ack;
    s_req |=> s_ack_pulse;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("ack not a single pulse");

  property p_chip_reset;
    chip_rst |=> cell_q == 10'h000;
  endproperty
  a_chip_reset: assert property (p_chip_reset) else $error("chip reset ignored");

  property p_clear_wins;
    !chip_rst && aclr && ald |=> cell_q == 10'h000;
  endproperty
  a_clear_wins: assert property (p_clear_wins) else $error("clear lost to preset");

  property p_preset;
    !chip_rst && !aclr && ald && preset_mode |=> cell_q == 10'h3ff;
  endproperty
  a_preset: assert property (p_preset) else $error("preset not all ones");

  property p_ald_data;
    !chip_rst && !aclr && ald && !preset_mode |=> cell_q == $past(third_data_in);
  endproperty
  a_ald_data: assert property (p_ald_data) else $error("load data wrong");

  property p_ena_hold;
    quiet && !ena |=> $stable(cell_q);
  endproperty
  a_ena_hold: assert property (p_ena_hold) else $error("register moved without enable");

  property p_sclr_first;
    quiet && ena && sclr |=> cell_q == 10'h000;
  endproperty
  a_sclr_first: assert property (p_sclr_first) else $error("sync clear lost");

  property p_sload;
    quiet && ena && !sclr && sload |=> cell_q == $past(third_data_in);
  endproperty
  a_sload: assert property (p_sload) else $error("sync load wrong");

  property p_adder;
    arith && start == 4'h0 && (&fourth_data_in)
      |-> comb_vec == model_sum[9:0] && carry10 == (model_sum[10] ^ addnsub ^ 1'b0)
          || addnsub;
  endproperty
  a_adder: assert property (p_adder) else $error("sum mismatch");

  property p_diff;
    arith && addnsub && start == 4'h0 && (&fourth_data_in)
      |-> comb_vec == 10'(operand_a_in - operand_b_in);
  endproperty
  a_diff: assert property (p_diff) else $error("difference mismatch");

  property p_carry_out;
    ##1 1'b1 |-> cluster_carry_out == $past(carry10);
  endproperty
  a_carry_out: assert property (p_carry_out) else $error("carry out not routed");

endmodule // cell_cluster

// File: tb/neighbour_cells.sv
/*
  Model of the previous linked cluster and its neighbouring cells.
  Assumes the bench hands it next values; it launches them on clk like real logic.
*/
module neighbour_cells (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic carry_next,
  input  wire logic lut_next,
  input  wire logic reg_next,
  output logic      cluster_carry_in,
  output logic      lut_chain_in,
  output logic      reg_chain_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Same-clock launch
  // ----------------------------------------------------------------
  // Neighbours are clocked logic, so their outputs change only after an edge.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cluster_carry_in <= 1'b0;
      lut_chain_in     <= 1'b0;
      reg_chain_in     <= 1'b0;
    end
    else
    begin
      cluster_carry_in <= carry_next;
      lut_chain_in     <= lut_next;
      reg_chain_in     <= reg_next;
    end
  end
endmodule // neighbour_cells

// File: tb/tb.sv
/*
  Self-checking bench for the logic cell cluster.
  Assumes the cluster answers Wishbone with a registered ack.
*/
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic        ack, cc_in, lc_in, rc_in, cout, lout, ab = 1'b0;
  logic        carry_next = 1'b0, lut_next = 1'b0, reg_next = 1'b0, rst_n = 1'b1;
  logic [9:0]  a = '0, b = '0, d3 = '0, d4 = '0, q;
  logic [10:0] s;
  logic [15:0] mask;
  integer      seed = 32'h4b1d4ccf, num_errors = 0, checked = 0, cycles = 0;
  always #25 clk = ~clk;
  cell_cluster cell_cluster_inst (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .operand_a_in(a), .operand_b_in(b),
    .third_data_in(d3), .fourth_data_in(d4), .cluster_carry_in(cc_in),
    .lut_chain_in(lc_in), .reg_chain_in(rc_in), .chip_wide_reset_n(rst_n),
    .cell_q(q), .cluster_carry_out(cout), .lut_chain_out(lout));
  neighbour_cells neighbour_cells_inst (.clk(clk), .sys_rst(sys_rst),
    .carry_next(carry_next), .lut_next(lut_next), .reg_next(reg_next),
    .cluster_carry_in(cc_in), .lut_chain_in(lc_in), .reg_chain_in(rc_in));
  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic [9:0] lut_exp(input logic [15:0] m);
    for (int i = 0; i < 10; i++)
      lut_exp[i] = m[{d4[i], d3[i], b[i], a[i]}];
  endfunction
  // With the look-up chain on, each cell's first input is the result below it.
  function automatic logic [9:0] lchain_exp(input logic [15:0] m);
    logic c;
    c = lc_in;
    for (int i = 0; i < 10; i++)
    begin
      c = m[{d4[i], d3[i], b[i], c}];
      lchain_exp[i] = c;
    end
  endfunction
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    wb(1'b0, 8'h00, 32'h0); `CHK(rd, 32'h0)
    wb(1'b0, 8'h08, 32'h0); `CHK(rd, 32'h8)
    wb(1'b1, 8'h0c, 32'hffffffff);
    wb(1'b0, 8'h10, 32'h0); `CHK(rd, 32'h0)
    wb(1'b0, 8'h0c, 32'h0); `CHK(rd[9:0], 10'h0)
    // Normal mode with a random table; addnsub toggles and must not matter.
    for (int k = 0; k < 6; k++)
    begin
      mask = $random(seed);
      wb(1'b1, 8'h04, {16'h0, mask});
      wb(1'b1, 8'h08, {28'h0, 4'h8 | k[0]});
      a <= $random(seed); b <= $random(seed); d3 <= $random(seed); d4 <= $random(seed);
      settle();
      `CHK(q, lut_exp(mask))
      `CHK(lout, lut_exp(mask) >> 9)
      wb(1'b0, 8'h0c, 32'h0); `CHK(rd[19:10], lut_exp(mask))
    end
    // Look-up chain from the neighbour through all ten cells.
    for (int k = 0; k < 2; k++)
    begin
      mask = $random(seed);
      wb(1'b1, 8'h04, {16'h0, mask});
      wb(1'b1, 8'h00, 32'h20);
      lut_next <= $random(seed);
      a <= $random(seed); b <= $random(seed); d3 <= $random(seed); d4 <= $random(seed);
      settle();
      `CHK(q, lchain_exp(mask))
      `CHK(lout, lchain_exp(mask) >> 9)
    end
    // Arithmetic mode: add with the cluster carry, then subtract.
    wb(1'b1, 8'h00, 32'h1);
    d3 <= 10'h0; d4 <= 10'h3ff;
    for (int k = 0; k < 8; k++)
    begin
      ab = k[2];
      wb(1'b1, 8'h08, {28'h0, 3'h4, ab});
      a <= (k == 0) ? 10'h3ff : $random(seed); b <= (k == 0) ? 10'h001 : $random(seed);
      carry_next <= $random(seed);
      settle();
      s = ab ? ({1'b0, a} + {1'b0, ~b} + 11'h1) : ({1'b0, a} + {1'b0, b} + cc_in);
      wb(1'b0, 8'h0c, 32'h0);
      `CHK(rd[19:10], s[9:0])
      `CHK(rd[20], s[10])
      `CHK(cout, s[10])
    end
    // Register controls in normal mode.
    wb(1'b1, 8'h00, 32'h0);
    d3 <= $random(seed);
    wb(1'b1, 8'h08, 32'h0e); settle(); `CHK(q, 10'h0)
    wb(1'b1, 8'h08, 32'h0c); settle(); `CHK(q, d3)
    wb(1'b1, 8'h08, 32'h04); d3 <= ~d3; settle(); `CHK(q, ~d3)
    wb(1'b1, 8'h08, 32'h58); settle(); `CHK(q, 10'h0)
    wb(1'b1, 8'h08, 32'h48); settle(); `CHK(q, d3)
    wb(1'b1, 8'h00, 32'h08); settle(); `CHK(q, 10'h3ff)
    wb(1'b1, 8'h08, 32'h68); settle(); `CHK(q, 10'h0)
    // Chip-wide reset beats a preset load.
    wb(1'b1, 8'h08, 32'h48);
    wb(1'b1, 8'h00, 32'h18);
    rst_n <= 1'b0; settle(); settle(); `CHK(q, 10'h0)
    rst_n <= 1'b1; settle(); settle(); `CHK(q, 10'h3ff)
    // Packed register fed by the register chain, a shift of ones.
    wb(1'b1, 8'h08, 32'h0a);
    wb(1'b1, 8'h00, 32'h04);
    settle(); `CHK(q, 10'h0)
    reg_next <= 1'b1;
    wb(1'b1, 8'h08, 32'h08);
    repeat (4) settle();
    `CHK(q, 10'h3ff)
    end_of_test();
  end
endmodule // tb
